// ---- inc/phy_cfg_pkg.sv ----
//////////////////////////////////////////////////////////////////////////////
// Purpose: constants for the port configuration and quick-status registers
// Assumes: 5-bit management register address, 16-bit register data
// Notes:   one port per instance
//////////////////////////////////////////////////////////////////////////////
package phy_cfg_pkg;

	// register addresses on the management register port
	localparam logic [4:0] CFG_ADDR   = 5'h10;
	localparam logic [4:0] STAT_ADDR  = 5'h11;

	// configuration bit positions
	localparam int CFG_FORCE_LINK  = 14;
	localparam int CFG_TX_DISABLE  = 13;
	localparam int CFG_SCR_BYPASS  = 12;
	localparam int CFG_JABBER_DIS  = 10;
	localparam int CFG_HEARTBEAT   = 9;
	localparam int CFG_LOOPBK_DIS  = 8;
	localparam int CFG_CRS_EXTEND  = 7;
	localparam int CFG_FIFO_DEEP   = 6;
	localparam int CFG_PREAMBLE    = 5;
	localparam int CFG_FEF_ENABLE  = 2;
	localparam int CFG_ALT_NP      = 1;
	localparam int CFG_FIBER       = 0;

	// reserved bits 15, 11, 4, 3 never store a one
	localparam logic [15:0] CFG_WRITE_MASK = 16'h77E7;
	// loopback disable, crs extend, far-end-fault enable set; media bit from strap
	localparam logic [15:0] CFG_RESET_VAL  = 16'h0184;

	// quick-status bit positions
	localparam int STAT_SPEED100   = 14;
	localparam int STAT_TX_ACT     = 13;
	localparam int STAT_RX_ACT     = 12;
	localparam int STAT_COLLISION  = 11;
	localparam int STAT_LINK       = 10;
	localparam int STAT_DUPLEX     = 9;
	localparam int STAT_AN_MODE    = 8;
	localparam int STAT_AN_DONE    = 7;
	localparam int STAT_POLARITY   = 5;
	localparam int STAT_PAUSE      = 4;
	localparam int STAT_ERROR      = 3;

	// elastic buffer sizing figures
	localparam int FIFO_SHORT_BYTES = 2048;
	localparam int FIFO_LONG_BYTES  = 10240;
	localparam int CLOCK_OFFSET_PPM = 450;

endpackage : phy_cfg_pkg

// ---- inc/port_status_if.sv ----
//////////////////////////////////////////////////////////////////////////////
// Purpose: live port state toward the quick-status collector
// Assumes: all signals on clk_sys
// Notes:   statusWord comes back registered
//////////////////////////////////////////////////////////////////////////////
interface port_status_if;
	logic        speed100Tp;
	logic        txActive;
	logic        rxActive;
	logic        collision;
	logic        linkPass;
	logic        fullDuplex;
	logic        anEnabled;
	logic        anComplete;
	logic        polarityReversed;
	logic        pauseCapable;
	logic        errorSeen;
	logic [15:0] statusWord;

	modport source (
		output speed100Tp, txActive, rxActive, collision, linkPass, fullDuplex,
		output anEnabled, anComplete, polarityReversed, pauseCapable, errorSeen,
		input  statusWord
	);
	modport collector (
		input  speed100Tp, txActive, rxActive, collision, linkPass, fullDuplex,
		input  anEnabled, anComplete, polarityReversed, pauseCapable, errorSeen,
		output statusWord
	);
endinterface : port_status_if

// ---- logic/quick_status_collect.sv ----
//////////////////////////////////////////////////////////////////////////////
// Purpose: assembles the read-only quick-status word each cycle
// Assumes: inputs are on clk_sys, no synchronisers needed
// Notes:   one cycle from port state to word
//////////////////////////////////////////////////////////////////////////////
module quick_status_collect (
	input  wire logic          clk_sys,
	input  wire logic          rst,
	input  wire logic          ce,
	port_status_if.collector   stat
);
	import phy_cfg_pkg::*;

	logic [15:0] word_d;
	logic [15:0] word_q;

	// reserved positions stay zero; nothing here is writable
	always_comb begin
		word_d                 = 16'h0000;
		word_d[STAT_SPEED100]  = stat.speed100Tp;
		word_d[STAT_TX_ACT]    = stat.txActive;
		word_d[STAT_RX_ACT]    = stat.rxActive;
		word_d[STAT_COLLISION] = stat.collision;
		word_d[STAT_LINK]      = stat.linkPass;
		word_d[STAT_DUPLEX]    = stat.fullDuplex;
		word_d[STAT_AN_MODE]   = stat.anEnabled;
		word_d[STAT_AN_DONE]   = stat.anComplete;
		word_d[STAT_POLARITY]  = stat.polarityReversed;
		word_d[STAT_PAUSE]     = stat.pauseCapable;
		word_d[STAT_ERROR]     = stat.errorSeen;
	end

	// register the word, frozen while ce is low
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			word_q <= 16'h0000;
		end else if (ce) begin
			word_q <= word_d;
		end
	end

	assign stat.statusWord = word_q;

endmodule : quick_status_collect

// ---- logic/phy_port_config_quick_status.sv ----
//////////////////////////////////////////////////////////////////////////////
// Purpose: per-port configuration register and quick-status register
// Assumes: management register port on clk_sys; port state on clk_sys
// Notes:   media strap is a pin and is synchronised before use
//////////////////////////////////////////////////////////////////////////////
// Function
// - force-link-pass makes status and link indicator show link up
// - transmit-disable stops TP transmitter; jabber-disable stops 10M jabber check
// - scrambler-bypass skips scrambler and descrambler in 100M TP mode
// - heartbeat bit is stored and read back, with no effect
// - loopback-disable, default one, stops 10M half-duplex TP loopback
// - carrier-sense select, default one, holds carrier sense in 10M TP mode until rx valid drops
// - FIFO-size bit picks elastic depth for 2 KB or 10 KB packets
// - preamble-enable moves 10M receive-valid start from SFD to carrier sense
// - far-end-fault code is sent only while its enable, default one, is set
// - alternate-next-page bit enables alternate next-page handling
// - media bit one selects fiber, zero twisted pair
// - media bit loads strap level at reset: low gives zero
// - reserved configuration bits store zero and read zero
// - speed bit shows 100M twisted-pair operation
// - transmit and receive activity bits follow packet activity
// - collision bit follows live state; link bit follows live state or force-link-pass
// - duplex bit shows full duplex; negotiation bit shows auto mode
// - negotiation-complete bit mirrors the standard status complete bit
// - polarity bit shows reversed TP polarity
// - pause bit shows pause capability
// - error bit shows an occurred error such as remote fault
//////////////////////////////////////////////////////////////////////////////
module phy_port_config_quick_status (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic        mediaSelectStrapPin,
	input  wire logic [4:0]  mgmtAddr,
	input  wire logic        mgmtWrite,
	input  wire logic        mgmtRead,
	input  wire logic [15:0] mgmtWrData,
	output logic      [15:0] mgmtRdData,
	output logic             mgmtRdValid,
	input  wire logic        speed100,
	input  wire logic        txActive,
	input  wire logic        rxActive,
	input  wire logic        collision,
	input  wire logic        linkUp,
	input  wire logic        fullDuplex,
	input  wire logic        anEnabled,
	input  wire logic        anComplete,
	input  wire logic        polarityReversed,
	input  wire logic        pauseCapable,
	input  wire logic        errorSeen,
	input  wire logic        rawCrs,
	input  wire logic        rxDataValid,
	input  wire logic        farEndFaultDetected,
	output logic             linkPass,
	output logic             tpTxEnable,
	output logic             scramblerBypassOn,
	output logic             jabberCheckOn,
	output logic             tpLoopbackOn,
	output logic             carrierSense,
	output logic             rxDvAtCrs,
	output logic             fifoDeep,
	output logic      [7:0]  elasticDepthBits,
	output logic             farEndFaultSend,
	output logic             altNextPageOn,
	output logic             fiberMode
);
	import phy_cfg_pkg::*;

	//////////////////////////////////////////////////////////////////////////
	// helpers

	// bits of slip a packet of this size can build at the clock offset
	function automatic logic [7:0] slipBits(input int bytes);
		longint prod;
		prod = longint'(bytes) * 64'd8 * 64'd2 * longint'(CLOCK_OFFSET_PPM);
		return 8'((prod + 64'd999999) / 64'd1000000);
	endfunction

	localparam logic [7:0] DEPTH_SHORT = slipBits(FIFO_SHORT_BYTES);
	localparam logic [7:0] DEPTH_LONG  = slipBits(FIFO_LONG_BYTES);

	//////////////////////////////////////////////////////////////////////////
	// strap synchroniser

	logic strapMeta_q;
	logic strapSync_q;

	// the pin is asynchronous; second stage is the only reader of the first
	always_ff @(posedge clk_sys) begin
		if (ce) begin
			strapMeta_q <= mediaSelectStrapPin;
			strapSync_q <= strapMeta_q;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// configuration register

	logic [15:0] cfg_d;
	logic [15:0] cfg_q;
	logic        cfgWrite;

	assign cfgWrite = mgmtWrite && (mgmtAddr == CFG_ADDR);

	// sync reset keeps loading the strap, so hold reset three edges or more
	always_comb begin
		cfg_d = cfg_q;
		if (rst) begin
			cfg_d             = CFG_RESET_VAL;
			cfg_d[CFG_FIBER]  = strapSync_q;
		end else if (cfgWrite) begin
			cfg_d = mgmtWrData & CFG_WRITE_MASK;
		end
	end

	// only the clock enable gates this; reset must still see ce high
	always_ff @(posedge clk_sys) begin
		if (ce) begin
			cfg_q <= cfg_d;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// quick-status collector

	port_status_if stat ();

	assign stat.speed100Tp       = speed100 && !cfg_q[CFG_FIBER];
	assign stat.txActive         = txActive;
	assign stat.rxActive         = rxActive;
	assign stat.collision        = collision;
	assign stat.linkPass         = linkUp || cfg_q[CFG_FORCE_LINK];
	assign stat.fullDuplex       = fullDuplex;
	assign stat.anEnabled        = anEnabled;
	assign stat.anComplete       = anComplete;
	assign stat.polarityReversed = polarityReversed;
	assign stat.pauseCapable     = pauseCapable;
	assign stat.errorSeen        = errorSeen;

	quick_status_collect u_collect (
		.clk_sys (clk_sys),
		.rst     (rst),
		.ce      (ce),
		.stat    (stat.collector)
	);

	//////////////////////////////////////////////////////////////////////////
	// register read path

	logic [15:0] rd_d;
	logic [15:0] rd_q;
	logic        rdv_d;
	logic        rdv_q;

	// unmapped addresses read zero; status writes fall through here unused
	always_comb begin
		rdv_d = mgmtRead;
		rd_d  = rd_q;
		if (mgmtRead) begin
			case (mgmtAddr)
				CFG_ADDR:  rd_d = cfg_q;
				STAT_ADDR: rd_d = stat.statusWord;
				default:   rd_d = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rd_q  <= 16'h0000;
			rdv_q <= 1'b0;
		end else if (ce) begin
			rd_q  <= rd_d;
			rdv_q <= rdv_d;
		end
	end

	assign mgmtRdData  = rd_q;
	assign mgmtRdValid = rdv_q;

	//////////////////////////////////////////////////////////////////////////
	// port control outputs

	typedef struct packed {
		logic       linkPass;
		logic       tpTxEnable;
		logic       scrBypass;
		logic       jabberOn;
		logic       loopbackOn;
		logic       crs;
		logic       dvAtCrs;
		logic       fifoDeep;
		logic [7:0] depth;
		logic       fefSend;
		logic       altNp;
		logic       fiber;
	} ctrl_type;

	ctrl_type ctl_d;
	ctrl_type ctl_q;
	logic     tenMeg;

	// 10M means twisted pair at low speed; fiber is always 100M
	assign tenMeg = !speed100 && !cfg_q[CFG_FIBER];

	always_comb begin
		ctl_d            = ctl_q;
		ctl_d.linkPass   = linkUp || cfg_q[CFG_FORCE_LINK];
		ctl_d.tpTxEnable = !cfg_q[CFG_TX_DISABLE] && !cfg_q[CFG_FIBER];
		ctl_d.jabberOn   = !cfg_q[CFG_JABBER_DIS] && tenMeg;
		ctl_d.scrBypass  = cfg_q[CFG_SCR_BYPASS] && speed100
			&& !cfg_q[CFG_FIBER];
		ctl_d.loopbackOn = !cfg_q[CFG_LOOPBK_DIS] && tenMeg && !fullDuplex;
		// in 10M TP mode, extension keeps crs up while receive-valid is still high
		ctl_d.crs        = rawCrs || (cfg_q[CFG_CRS_EXTEND] && tenMeg
			&& rxDataValid);
		ctl_d.dvAtCrs    = cfg_q[CFG_PREAMBLE] && tenMeg;
		ctl_d.fifoDeep   = cfg_q[CFG_FIFO_DEEP];
		ctl_d.depth      = cfg_q[CFG_FIFO_DEEP] ? DEPTH_LONG : DEPTH_SHORT;
		ctl_d.fefSend    = cfg_q[CFG_FEF_ENABLE] && farEndFaultDetected;
		ctl_d.altNp      = cfg_q[CFG_ALT_NP];
		ctl_d.fiber      = cfg_q[CFG_FIBER];
	end

	// all zero in reset so nothing transmits before the config settles
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctl_q <= '0;
		end else if (ce) begin
			ctl_q <= ctl_d;
		end
	end

	assign linkPass          = ctl_q.linkPass;
	assign tpTxEnable        = ctl_q.tpTxEnable;
	assign scramblerBypassOn = ctl_q.scrBypass;
	assign jabberCheckOn     = ctl_q.jabberOn;
	assign tpLoopbackOn      = ctl_q.loopbackOn;
	assign carrierSense      = ctl_q.crs;
	assign rxDvAtCrs         = ctl_q.dvAtCrs;
	assign fifoDeep          = ctl_q.fifoDeep;
	assign elasticDepthBits  = ctl_q.depth;
	assign farEndFaultSend   = ctl_q.fefSend;
	assign altNextPageOn     = ctl_q.altNp;
	assign fiberMode         = ctl_q.fiber;

	//////////////////////////////////////////////////////////////////////////
	// checks

	AST_FORCE_LINK: assert property (
		@(posedge clk_sys) disable iff (rst)
		(ce && cfg_q[CFG_FORCE_LINK]) |=> linkPass && stat.statusWord[STAT_LINK])
		else $error("forced link not reported as pass");

	AST_TX_DISABLE: assert property (
		@(posedge clk_sys) disable iff (rst)
		(ce && cfg_q[CFG_TX_DISABLE]) |=> !tpTxEnable)
		else $error("transmitter enabled while disabled");

	AST_SCR_BYPASS: assert property (
		@(posedge clk_sys) disable iff (rst)
		(ce && (cfg_q[CFG_SCR_BYPASS] && speed100 && !cfg_q[CFG_FIBER]))
		|=> scramblerBypassOn)
		else $error("scrambler bypass not applied");

	AST_LOOPBACK: assert property (
		@(posedge clk_sys) disable iff (rst)
		(ce && cfg_q[CFG_LOOPBK_DIS]) |=> !tpLoopbackOn)
		else $error("loopback active while disabled");

	AST_CRS_EXTEND: assert property (
		@(posedge clk_sys) disable iff (rst)
		(ce && cfg_q[CFG_CRS_EXTEND] && tenMeg && rxDataValid) |=> carrierSense)
		else $error("carrier sense dropped before receive valid");

	AST_RESERVED_ZERO: assert property (
		@(posedge clk_sys) disable iff (rst)
		(cfg_q & ~CFG_WRITE_MASK) == 16'h0000)
		else $error("reserved config bit holds a one");

	AST_WRITE_BACK: assert property (
		@(posedge clk_sys) disable iff (rst)
		(ce && cfgWrite) |=> cfg_q == ($past(mgmtWrData) & CFG_WRITE_MASK))
		else $error("config write not stored");

	// strap flops start unknown, so only judge once reset has filled the synchroniser
	AST_STRAP_LOAD: assert property (
		@(posedge clk_sys)
		(ce && rst && $past(rst) && $past(rst, 2))
		|=> cfg_q[CFG_FIBER] == $past(strapSync_q))
		else $error("media bit not loaded from strap");

	AST_STAT_READ: assert property (
		@(posedge clk_sys) disable iff (rst)
		(ce && mgmtRead && mgmtAddr == STAT_ADDR)
		|=> mgmtRdValid && (mgmtRdData & 16'h8047) == 16'h0000)
		else $error("status reserved bits not zero");

	AST_FEF_GATE: assert property (
		@(posedge clk_sys) disable iff (rst)
		(ce && !cfg_q[CFG_FEF_ENABLE]) |=> !farEndFaultSend)
		else $error("far-end fault sent while disabled");

endmodule : phy_port_config_quick_status

// ---- verif/mgmt_master.sv ----
//////////////////////////////////////////////////////////////////////////////
// Purpose: station management master model for the register port
// Assumes: one-cycle strobes, requests launched just after a rising edge
// Notes:   data is sent as given, so a caller can break the reserved-zero habit
//////////////////////////////////////////////////////////////////////////////
module mgmt_master (
	input  wire logic        clk_sys,
	output logic      [4:0]  mgmtAddr,
	output logic             mgmtWrite,
	output logic             mgmtRead,
	output logic      [15:0] mgmtWrData
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		mgmtAddr   = 5'h00;
		mgmtWrite  = 1'b0;
		mgmtRead   = 1'b0;
		mgmtWrData = 16'h0000;
	end
	// one write strobe; idle data is inverted so stale values never look valid
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		mgmtAddr   <= a;
		mgmtWrData <= d;
		mgmtWrite  <= 1'b1;
		@(posedge clk_sys);
		mgmtWrite  <= 1'b0;
		mgmtWrData <= ~d;
	endtask
	// one read strobe; answer is picked up by the bench monitor
	task automatic rd(input logic [4:0] a);
		@(posedge clk_sys);
		mgmtAddr <= a;
		mgmtRead <= 1'b1;
		@(posedge clk_sys);
		mgmtRead <= 1'b0;
	endtask
endmodule // mgmt_master

// ---- verif/tb_phy_port_config_quick_status.sv ----
//////////////////////////////////////////////////////////////////////////////
// Purpose: self-checking bench for configuration and quick-status registers
// Assumes: reads answered one cycle after the strobe, outputs one cycle late
// Notes:   random config and port state from a fixed seed
//////////////////////////////////////////////////////////////////////////////
module tb_phy_port_config_quick_status;
	timeunit 1ns;
	timeprecision 1ps;
	import phy_cfg_pkg::*;
	logic        clk_sys = 1'b0;
	logic        rst     = 1'b1;
	logic        ce      = 1'b1;
	logic        strap   = 1'b1;
	logic [10:0] st      = '0;
	logic [2:0]  ex      = '0;
	logic [4:0]  mgmtAddr;
	logic        mgmtWrite;
	logic        mgmtRead;
	logic [15:0] mgmtWrData;
	logic [15:0] mgmtRdData;
	logic        mgmtRdValid;
	logic [11:0] outs;
	logic [7:0]  depth;
	logic [15:0] expQ[$];
	logic [15:0] cfg;
	logic [15:0] stw;
	int          n_fail  = 0;
	int          n_tests = 0;
	int          cycles  = 0;
	//////////////////////////////////////////////////////////////////////////
	// clock and hang guard
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 8000) begin
			n_fail++;
			finish_test();
		end
	end
	mgmt_master mgmt_master_i (
		.clk_sys(clk_sys), .mgmtAddr(mgmtAddr), .mgmtWrite(mgmtWrite),
		.mgmtRead(mgmtRead), .mgmtWrData(mgmtWrData)
	);
	phy_port_config_quick_status phy_port_config_quick_status_i (
		.clk_sys(clk_sys), .rst(rst), .ce(ce), .mediaSelectStrapPin(strap),
		.mgmtAddr(mgmtAddr), .mgmtWrite(mgmtWrite), .mgmtRead(mgmtRead),
		.mgmtWrData(mgmtWrData), .mgmtRdData(mgmtRdData), .mgmtRdValid(mgmtRdValid),
		.speed100(st[10]), .txActive(st[9]), .rxActive(st[8]), .collision(st[7]),
		.linkUp(st[6]), .fullDuplex(st[5]), .anEnabled(st[4]), .anComplete(st[3]),
		.polarityReversed(st[2]), .pauseCapable(st[1]), .errorSeen(st[0]),
		.rawCrs(ex[2]), .rxDataValid(ex[1]), .farEndFaultDetected(ex[0]),
		.linkPass(outs[11]), .tpTxEnable(outs[10]), .scramblerBypassOn(outs[9]),
		.jabberCheckOn(outs[8]), .tpLoopbackOn(outs[7]), .carrierSense(outs[6]),
		.rxDvAtCrs(outs[5]), .fifoDeep(outs[4]), .elasticDepthBits(depth),
		.farEndFaultSend(outs[3]), .altNextPageOn(outs[2]), .fiberMode(outs[1])
	);
	assign outs[0] = 1'b0;
	//////////////////////////////////////////////////////////////////////////
	// comparison and report helpers
	task automatic chkRd(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t read got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chkOut(input logic [19:0] got, input logic [19:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t outputs got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("tests %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// oldest expected read against each answer; a stray answer is a mismatch
	always @(posedge clk_sys) begin
		if (mgmtRdValid === 1'b1) begin
			if (expQ.size() == 0) begin
				chkRd(mgmtRdData, 16'hDEAD);
			end else begin
				chkRd(mgmtRdData, expQ.pop_front());
			end
		end
	end
	task automatic rdExp(input logic [4:0] a, input logic [15:0] e);
		expQ.push_back(e);
		mgmt_master_i.rd(a);
	endtask
	task automatic doReset(input logic s);
		@(posedge clk_sys);
		rst   <= 1'b1;
		strap <= s;
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
	endtask
	// status word and control outputs worked out from config and port state
	function automatic logic [15:0] statExp(input logic [15:0] c, input logic [10:0] s);
		return {1'b0, s[10] & ~c[0], s[9:7], s[6] | c[14], s[5:3], 1'b0,
			s[2:0], 3'b000};
	endfunction
	function automatic logic [19:0] outExp(input logic [15:0] c, input logic [10:0] s,
		input logic [2:0] e);
		logic tp10;
		tp10 = ~s[10] & ~c[0];
		return {s[6] | c[14], ~c[13] & ~c[0], c[12] & s[10] & ~c[0], ~c[10] & tp10,
			~c[8] & tp10 & ~s[5], e[2] | (c[7] & tp10 & e[1]), c[5] & tp10, c[6],
			e[0] & c[2], c[1], c[0], 1'b0, c[6] ? 8'h4A : 8'h0F};
	endfunction
	//////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		void'($urandom(61238));
		doReset(1'b1);
		rdExp(CFG_ADDR, 16'h0185);
		doReset(1'b0);
		rdExp(CFG_ADDR, 16'h0184);
		repeat (3) @(posedge clk_sys);
		#1;
		chkOut({outs, depth}, outExp(16'h0184, st, ex));
		$display("test reset defaults done");
		mgmt_master_i.wr(CFG_ADDR, 16'hFFFF);
		rdExp(CFG_ADDR, 16'h77E7);
		$display("test reserved bits done");
		// a write strobe seen only while ce is low must leave the config alone
		@(posedge clk_sys);
		ce <= 1'b0;
		mgmt_master_i.wr(CFG_ADDR, 16'h0000);
		ce <= 1'b1;
		rdExp(CFG_ADDR, 16'h77E7);
		$display("test clock enable hold done");
		for (int i = 0; i < 24; i++) begin
			cfg = 16'($urandom()) & CFG_WRITE_MASK;
			@(posedge clk_sys);
			st <= 11'($urandom());
			ex <= 3'($urandom());
			mgmt_master_i.wr(CFG_ADDR, cfg);
			rdExp(CFG_ADDR, cfg);
			stw = statExp(cfg, st);
			rdExp(STAT_ADDR, stw);
			mgmt_master_i.wr(STAT_ADDR, 16'($urandom()));
			rdExp(STAT_ADDR, stw);
			rdExp(5'h05, 16'h0000);
			#1;
			chkOut({outs, depth}, outExp(cfg, st, ex));
			chkOut({outs, depth}, outExp(cfg, st, ex));
		end
		repeat (4) @(posedge clk_sys);
		chkRd(16'(expQ.size()), 16'h0000);
		$display("test random config and status done");
		finish_test();
	end
endmodule // tb_phy_port_config_quick_status
